//--- common/psm_map.svh
// Purpose: Constants for the power-save mode controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Operand codes for the two modes are local encodings.
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

// ----------------------------------------------------------------
// Power-save instruction operand
// ----------------------------------------------------------------
`define PSM_OPERAND_W      8
`define PSM_OPERAND_SLEEP  8'h00
`define PSM_OPERAND_IDLE   8'h01

// ----------------------------------------------------------------
// Oscillator control register field
// ----------------------------------------------------------------
`define PSM_OSC_SEL_MSB    10
`define PSM_OSC_SEL_LSB    8
`define PSM_OSC_SEL_W      3
`define PSM_OSC_SEL_RESET  3'h0

`endif

//--- common/psm_pkg.sv
// Purpose: Types for the power-save mode controller.
// Assumes: Nothing beyond the map header.
// Notes:   One-hot state codes are written out.
package psm_pkg;

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSM_RUN   = 3'b001,
    PSM_IDLE  = 3'b010,
    PSM_SLEEP = 3'b100
  } psm_mode_e;

endpackage

//--- hdl/psm_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous wake sources.
// Assumes: Single clock ref_clk, synchronous reset.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module psm_sync2 (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Data
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // Next values
  always_comb begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

`default_nettype wire

//--- hdl/psm_ctrl.sv
// Purpose: Sleep/Idle mode control and oscillator source select.
// Assumes: Core presents the power-save instruction as a one-cycle
//          strobe with its operand; clock gates act on enables.
// Notes:   Wake sources from pins are synchronised before use.
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"

module psm_ctrl (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Power-save instruction from the core
  input  wire logic                         powerSaveInstruction,
  input  wire logic [`PSM_OPERAND_W-1:0]    powerSaveOperand,
  // Wake sources
  input  wire logic                         enabledIrq,
  input  wire logic                         watchdogTimeout,
  // Oscillator control register write port
  input  wire logic                         clockConfigLocked,
  input  wire logic                         oscCtrlWrite,
  input  wire logic [15:0]                  oscCtrlWdata,
  // Clock gate enables and status
  output logic                              cpuClkEn,
  output logic                              periphClkEn,
  output logic                              sysClkEn,
  output logic                              inSleep,
  output logic                              inIdle,
  output logic                              wakeEvent,
  output logic [`PSM_OSC_SEL_W-1:0]         newOscillatorSelect
);

  // ----------------------------------------------------------------
  // Wake source synchronisers
  // ----------------------------------------------------------------
  logic irqSync;
  logic wdtSync;

  // Costs two cycles of wake latency, but no metastable state bit
  psm_sync2 uIrqSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .asyncIn (enabledIrq),
    .syncOut (irqSync)
  );

  psm_sync2 uWdtSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .asyncIn (watchdogTimeout),
    .syncOut (wdtSync)
  );

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  psm_pkg::psm_mode_e mode;
  psm_pkg::psm_mode_e next_mode;
  logic               next_wakeEvent;
  logic               wakeReq;

  // Either wake source ends a power-save mode
  assign wakeReq = irqSync | wdtSync;

  // Next mode; only the instruction strobe leaves RUN
  always_comb begin
    next_mode      = mode;
    next_wakeEvent = 1'b0;
    case (mode)
      psm_pkg::PSM_RUN: begin
        if (powerSaveInstruction) begin
          if (powerSaveOperand == `PSM_OPERAND_SLEEP) begin
            next_mode = psm_pkg::PSM_SLEEP;
          end else if (powerSaveOperand == `PSM_OPERAND_IDLE) begin
            next_mode = psm_pkg::PSM_IDLE;
          end
        end
      end
      psm_pkg::PSM_IDLE, psm_pkg::PSM_SLEEP: begin
        if (wakeReq) begin
          next_mode      = psm_pkg::PSM_RUN;
          next_wakeEvent = 1'b1;
        end
      end
      default: begin
        next_mode = psm_pkg::PSM_RUN;
      end
    endcase
  end

  // Reset is itself a wake: always return to RUN
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode      <= psm_pkg::PSM_RUN;
      wakeEvent <= 1'b0;
    end else begin
      mode      <= next_mode;
      wakeEvent <= next_wakeEvent;
    end
  end

  // ----------------------------------------------------------------
  // Clock gate enables
  // ----------------------------------------------------------------
  // Sleep drops every enable; Idle drops only the CPU clock
  always_comb begin
    sysClkEn    = (mode != psm_pkg::PSM_SLEEP);
    cpuClkEn    = (mode == psm_pkg::PSM_RUN);
    periphClkEn = (mode != psm_pkg::PSM_SLEEP);
    inSleep     = (mode == psm_pkg::PSM_SLEEP);
    inIdle      = (mode == psm_pkg::PSM_IDLE);
  end

  // ----------------------------------------------------------------
  // New oscillator select field
  // ----------------------------------------------------------------
  logic [`PSM_OSC_SEL_W-1:0] next_newOscillatorSelect;

  // Lock blocks the write silently; no error is reported
  always_comb begin
    next_newOscillatorSelect = newOscillatorSelect;
    if (oscCtrlWrite && !clockConfigLocked) begin
      next_newOscillatorSelect = oscCtrlWdata[`PSM_OSC_SEL_MSB:`PSM_OSC_SEL_LSB];
    end
  end

  // Select register; reset returns the default source
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      newOscillatorSelect <= `PSM_OSC_SEL_RESET;
    end else begin
      newOscillatorSelect <= next_newOscillatorSelect;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks rest while reset holds the block in RUN
  sleep_gates_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inSleep |-> (!sysClkEn && !cpuClkEn && !periphClkEn))
    else $error("Clocks running in Sleep");

  idle_periph_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inIdle |-> (!cpuClkEn && periphClkEn && sysClkEn))
    else $error("Idle clock enables wrong");

  entry_by_instr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!inSleep && !inIdle) ##1 (inSleep || inIdle) |-> $past(powerSaveInstruction))
    else $error("Power-save mode entered without instruction");

  wake_to_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((inSleep || inIdle) && wakeReq) |=> (cpuClkEn && wakeEvent))
    else $error("Wake request did not resume CPU");

  irq_wake_latency_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (inIdle && $rose(enabledIrq)) ##1 enabledIrq[*2] |-> ##[0:1] cpuClkEn)
    else $error("Interrupt wake too slow");

  sleep_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cpuClkEn && powerSaveInstruction && powerSaveOperand == `PSM_OPERAND_SLEEP) |=> inSleep)
    else $error("Sleep operand not decoded");

  idle_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cpuClkEn && powerSaveInstruction && powerSaveOperand == `PSM_OPERAND_IDLE) |=> inIdle)
    else $error("Idle operand not decoded");

  osc_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (oscCtrlWrite && !clockConfigLocked) |=>
      newOscillatorSelect == $past(oscCtrlWdata[`PSM_OSC_SEL_MSB:`PSM_OSC_SEL_LSB]))
    else $error("Oscillator select not written");

  osc_locked_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clockConfigLocked |=> $stable(newOscillatorSelect))
    else $error("Oscillator select changed while locked");

endmodule

`default_nettype wire

//--- dv/psm_core_model.sv
// Purpose: Core and peripheral stand-in for the mode controller.
// Assumes: Core issues instructions only while its clock runs.
// Notes:   Counters show which clock domains really ran.
`timescale 1ns/1ps
`default_nettype none
module psm_core_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Bench request and clock enables
  input  wire logic        issueReq,
  input  wire logic [7:0]  issueOp,
  input  wire logic        cpuClkEn,
  input  wire logic        periphClkEn,
  // Instruction out and activity counts
  output logic             powerSaveInstruction,
  output logic [7:0]       powerSaveOperand,
  output logic [15:0]      execCount,
  output logic [15:0]      periphCount
);
  // ----------------------------------------------------------
  // Core and peripheral activity
  // ----------------------------------------------------------
  // Stale operand is inverted every cycle, so it matches the last fresh one again on alternate cycles
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      powerSaveInstruction <= 1'b0;
      powerSaveOperand <= 8'h00;
      execCount <= 16'h0000;
      periphCount <= 16'h0000;
    end else begin
      powerSaveInstruction <= issueReq && cpuClkEn;
      powerSaveOperand <= issueReq ? issueOp : ~powerSaveOperand;
      execCount <= execCount + 16'(cpuClkEn);
      periphCount <= periphCount + 16'(periphClkEn);
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the power-save controller.
// Assumes: Operand codes and wake latency as handed over.
// Notes:   Mode rows in a table; osc and reset cases by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] op; logic dog; logic sleep; logic idle;} psm_row_s;
  logic ref_clk, sys_rst, issueReq, enabledIrq, watchdogTimeout, clockConfigLocked, oscCtrlWrite;
  logic powerSaveInstruction, cpuClkEn, periphClkEn, sysClkEn, inSleep, inIdle, wakeEvent;
  logic [7:0]  issueOp, powerSaveOperand;
  logic [15:0] oscCtrlWdata, execCount, periphCount, e0, p0;
  logic [2:0]  newOscillatorSelect;
  int          failures, checkCount;
  psm_row_s    rows [3];
  psm_row_s    r;
  psm_ctrl psm_ctrl_i (.ref_clk, .sys_rst, .powerSaveInstruction, .powerSaveOperand, .enabledIrq,
    .watchdogTimeout, .clockConfigLocked, .oscCtrlWrite, .oscCtrlWdata, .cpuClkEn, .periphClkEn,
    .sysClkEn, .inSleep, .inIdle, .wakeEvent, .newOscillatorSelect);
  psm_core_model psm_core_model_i (.ref_clk, .sys_rst, .issueReq, .issueOp, .cpuClkEn, .periphClkEn,
    .powerSaveInstruction, .powerSaveOperand, .execCount, .periphCount);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [15:0] st();
    return {10'h000, inSleep, inIdle, cpuClkEn, periphClkEn, sysClkEn, wakeEvent};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request held one edge so the core strobes exactly once
  task automatic issue(input logic [7:0] op);
    issueReq <= 1'b1;
    issueOp <= op;
    @(posedge ref_clk);
    issueReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic act(input logic [15:0] de, input logic [15:0] dp);
    e0 = execCount;
    p0 = periphCount;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(execCount - e0, de);
    chk(periphCount - p0, dp);
  endtask
  task automatic wake(input logic dog);
    int i;
    @(posedge ref_clk);
    enabledIrq <= !dog;
    watchdogTimeout <= dog;
    for (i = 0; i < 8 && wakeEvent !== 1'b1; i++) @(negedge ref_clk);
    if (i == 8) begin
      failures++;
      conclude();
    end
    // Drive edge, then two sync edges and the state edge
    chk(16'(i), 16'h0004);
    chk(st(), 16'h000F);
    @(negedge ref_clk);
    chk(st(), 16'h000E);
    @(posedge ref_clk);
    enabledIrq <= 1'b0;
    watchdogTimeout <= 1'b0;
  endtask
  // ----------------------------------------------------------
  // Clock, hang guard and main sequence
  // ----------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // A stuck sequence still reaches the verdict
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    conclude();
  end
  initial begin
    {sys_rst, issueReq, enabledIrq, watchdogTimeout, clockConfigLocked, oscCtrlWrite} = 6'h20;
    issueOp = 8'h00;
    oscCtrlWdata = 16'h0000;
    failures = 0;
    checkCount = 0;
    // Idle wakes on the interrupt so its latency check is reached
    rows[0] = '{8'h00, 1'b1, 1'b1, 1'b0};
    rows[1] = '{8'h01, 1'b0, 1'b0, 1'b1};
    rows[2] = '{8'h5A, 1'b0, 1'b0, 1'b0};
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk(st(), 16'h000E);
    for (int k = 0; k < 3; k++) begin
      r = rows[k];
      @(posedge ref_clk);
      issue(r.op);
      chk(st(), {10'h000, r.sleep, r.idle, !(r.sleep | r.idle), !r.sleep, !r.sleep, 1'b0});
      act((r.sleep | r.idle) ? 16'h0000 : 16'h0004, r.sleep ? 16'h0000 : 16'h0004);
      if (r.sleep | r.idle) wake(r.dog);
    end
    // Write, locked write, then write with all other bits set
    @(posedge ref_clk);
    oscCtrlWrite <= 1'b1;
    oscCtrlWdata <= 16'h0500;
    @(posedge ref_clk);
    clockConfigLocked <= 1'b1;
    oscCtrlWdata <= 16'h0300;
    @(negedge ref_clk);
    chk(16'(newOscillatorSelect), 16'h0005);
    @(posedge ref_clk);
    clockConfigLocked <= 1'b0;
    oscCtrlWdata <= 16'hFEFF;
    @(negedge ref_clk);
    chk(16'(newOscillatorSelect), 16'h0005);
    @(posedge ref_clk);
    oscCtrlWrite <= 1'b0;
    @(negedge ref_clk);
    chk(16'(newOscillatorSelect), 16'h0006);
    // Reset must wake from Sleep and clear the select
    @(posedge ref_clk);
    issue(8'h00);
    chk(st(), 16'h0020);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk(st(), 16'h000E);
    chk(16'(newOscillatorSelect), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
